// [rtl/wdt_pkg.sv]
// Package with the register map, field layout and timing constants of the watchdog and countdown timer.
package wdt_pkg;
  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_IRQ_CFG = 8'h02;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] IDX_TIMER_VALUE = 8'h11;
  localparam int ADDR_WIDTH = 12;
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_CFG = {2'h0, IDX_IRQ_CFG, 2'h0};
  localparam logic [11:0] ADDR_TIMER_CONTROL = {2'h0, IDX_TIMER_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_TIMER_VALUE = {2'h0, IDX_TIMER_VALUE, 2'h0};
  // Field positions.
  localparam int CTRL_MODE_MSB = 7;
  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_PULSE_BIT = 5;
  localparam int CTRL_SRC_MSB = 1;
  localparam int CTRL_SRC_LSB = 0;
  localparam int STAT_MS_BIT = 7;
  localparam int STAT_WD_BIT = 6;
  localparam int STAT_CD_BIT = 3;
  localparam int CFG_CD_IE_BIT = 0;
  localparam int CFG_MS_IE_BIT = 1;
  // Values after reset.
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic PULSE_RESET = 1'b0;
  localparam logic [1:0] SRC_RESET = 2'h3;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [1:0] CFG_RESET = 2'h0;
  // Modes of the timer.
  typedef enum logic [1:0] {
    WDT_MODE_OFF = 2'h0,
    WDT_MODE_CD = 2'h1,
    WDT_MODE_WD_INT = 2'h2,
    WDT_MODE_WD_RST = 2'h3
  } wdt_mode_t;
  // Tick sources.
  localparam logic [1:0] SRC_4K = 2'h0;
  localparam logic [1:0] SRC_64 = 2'h1;
  localparam logic [1:0] SRC_1 = 2'h2;
  localparam logic [1:0] SRC_60S = 2'h3;
  // Timing.
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_4K_HZ = 4096;
  localparam int TICK_4K_CYC = CLK_HZ / TICK_4K_HZ;
  localparam logic [5:0] DIV_64_LAST = 6'h3f;
  localparam logic [5:0] DIV_1_LAST = 6'h3f;
  localparam logic [5:0] DIV_60_LAST = 6'h3b;
  localparam int RST_FAST_NS = 244_000;
  localparam int RST_SLOW_NS = 15_625_000;
  localparam int RST_FAST_CYC = RST_FAST_NS / CLK_PERIOD_NS;
  localparam int RST_SLOW_CYC = RST_SLOW_NS / CLK_PERIOD_NS;
endpackage

// [rtl/wdt_timer.sv]
// Watchdog and countdown timer with its APB register slave and tick prescaler.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
module wdt_timer #(
  parameter int TICK_4K_CYC = wdt_pkg::TICK_4K_CYC,
  parameter int RST_FAST_CYC = wdt_pkg::RST_FAST_CYC,
  parameter int RST_SLOW_CYC = wdt_pkg::RST_SLOW_CYC
) (
  input wire logic clk_i, // System clock, 100 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB direction, high for write.
  input wire logic [11:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error for unmapped address.
  input wire logic ms_event_i, // One-cycle minute/second event.
  output logic irq_n_o, // Interrupt output, active low.
  output logic wd_rst_n_o // Watchdog reset output, active low.
);
  logic [1:0] mode_reg;
  logic pulse_sel_reg;
  logic [1:0] src_reg;
  logic [7:0] reload_reg;
  logic [7:0] cnt_reg;
  logic running_reg;
  logic first_reg;
  logic wd_expired_reg;
  logic cd_done_reg;
  logic ms_flag_reg;
  logic [1:0] cfg_reg;
  logic [14:0] div_reg;
  logic [5:0] c64_reg;
  logic [5:0] c1_reg;
  logic [5:0] c60_reg;
  logic t4k;
  logic t64;
  logic t1;
  logic t60;
  logic tick;
  logic [20:0] rst_cnt_reg;
  logic rst_act_reg;
  logic pulse_reg;
  logic irq_n_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic val_wr;
  logic stat_wr;
  logic stat_rd;
  logic wd_mode;
  logic cd_mode;
  logic cd_hit;
  logic wd_hit;
  logic ms_set;

  // Address decode used for writes and the error answer.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == wdt_pkg::ADDR_STATUS) || (a == wdt_pkg::ADDR_IRQ_CFG) ||
             (a == wdt_pkg::ADDR_TIMER_CONTROL) || (a == wdt_pkg::ADDR_TIMER_VALUE);
  endfunction

  // The slave never waits, so every access phase completes in one cycle.
  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i && mapped(paddr_i);
  assign rd = acc && !pwrite_i;
  assign val_wr = wr && (paddr_i == wdt_pkg::ADDR_TIMER_VALUE);
  assign stat_wr = wr && (paddr_i == wdt_pkg::ADDR_STATUS);
  assign stat_rd = rd && (paddr_i == wdt_pkg::ADDR_STATUS);
  assign pready_o = 1'b1;
  assign prdata_o = prdata_reg;
  assign pslverr_o = slverr_reg;
  assign irq_n_o = irq_n_reg;
  assign wd_rst_n_o = !rst_act_reg;

  // Mode decode; the countdown is unavailable whenever a watchdog mode is set.
  assign wd_mode = mode_reg[1];
  assign cd_mode = (mode_reg == wdt_pkg::WDT_MODE_CD);

  // Free-running prescaler chain; a software write never restarts it.
  assign t4k = (div_reg == 15'(TICK_4K_CYC - 1));
  assign t64 = t4k && (c64_reg == wdt_pkg::DIV_64_LAST);
  assign t1 = t64 && (c1_reg == wdt_pkg::DIV_1_LAST);
  assign t60 = t1 && (c60_reg == wdt_pkg::DIV_60_LAST);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 15'h0000;
      c64_reg <= 6'h00;
      c1_reg <= 6'h00;
      c60_reg <= 6'h00;
    end else begin
      div_reg <= t4k ? 15'h0000 : div_reg + 15'h0001;
      if (t4k) begin
        c64_reg <= c64_reg + 6'h01;
      end
      if (t64) begin
        c1_reg <= c1_reg + 6'h01;
      end
      if (t1) begin
        c60_reg <= (c60_reg == wdt_pkg::DIV_60_LAST) ? 6'h00 : c60_reg + 6'h01;
      end
    end
  end

  // Tick select shared by both timers.
  always_comb begin
    case (src_reg)
      wdt_pkg::SRC_4K: tick = t4k;
      wdt_pkg::SRC_64: tick = t64;
      wdt_pkg::SRC_1: tick = t1;
      default: tick = t60;
    endcase
  end

  // Control and interrupt configuration registers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= wdt_pkg::MODE_RESET;
      pulse_sel_reg <= wdt_pkg::PULSE_RESET;
      src_reg <= wdt_pkg::SRC_RESET;
      cfg_reg <= wdt_pkg::CFG_RESET;
    end else if (wr && paddr_i == wdt_pkg::ADDR_TIMER_CONTROL) begin
      mode_reg <= pwdata_i[wdt_pkg::CTRL_MODE_MSB:wdt_pkg::CTRL_MODE_LSB];
      pulse_sel_reg <= pwdata_i[wdt_pkg::CTRL_PULSE_BIT];
      src_reg <= pwdata_i[wdt_pkg::CTRL_SRC_MSB:wdt_pkg::CTRL_SRC_LSB];
    end else if (wr && paddr_i == wdt_pkg::ADDR_IRQ_CFG) begin
      cfg_reg <= {pwdata_i[wdt_pkg::CFG_MS_IE_BIT], pwdata_i[wdt_pkg::CFG_CD_IE_BIT]};
    end
  end

  // Terminal count events; a value write in the same cycle takes priority.
  assign cd_hit = cd_mode && running_reg && tick && !first_reg && (cnt_reg == 8'h01) && !val_wr;
  assign wd_hit = wd_mode && running_reg && tick && !first_reg && (cnt_reg == 8'h01) && !val_wr;

  // Down-counter. The first tick after a load is swallowed so that the first
  // period lands between n and n+1 ticks instead of possibly short of n.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_reg <= wdt_pkg::VALUE_RESET;
      cnt_reg <= wdt_pkg::VALUE_RESET;
      running_reg <= 1'b0;
      first_reg <= 1'b0;
    end else if (val_wr) begin
      reload_reg <= pwdata_i[7:0];
      cnt_reg <= pwdata_i[7:0];
      running_reg <= (pwdata_i[7:0] != 8'h00);
      first_reg <= 1'b1;
    end else if (running_reg && mode_reg != wdt_pkg::WDT_MODE_OFF && tick) begin
      first_reg <= 1'b0;
      if (first_reg) begin
        cnt_reg <= cnt_reg;
      end else if (cd_hit) begin
        cnt_reg <= reload_reg;
      end else if (wd_hit) begin
        running_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // Flags; a hardware set wins over a status clear in the same cycle, but a value write suppresses the watchdog set.
  assign ms_set = ms_event_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_expired_reg <= 1'b0;
      cd_done_reg <= 1'b0;
      ms_flag_reg <= 1'b0;
    end else begin
      wd_expired_reg <= wd_hit || (wd_expired_reg && !val_wr && !stat_rd);
      cd_done_reg <= cd_hit || (cd_done_reg && !(stat_wr && !pwdata_i[wdt_pkg::STAT_CD_BIT]));
      ms_flag_reg <= ms_set || (ms_flag_reg && !(stat_wr && !pwdata_i[wdt_pkg::STAT_MS_BIT]));
    end
  end

  // Reset pulse of fixed width per tick source (fast for 4K, slow otherwise); a value write ends it early.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt_reg <= 21'h000000;
      rst_act_reg <= 1'b0;
    end else if (wd_hit && mode_reg == wdt_pkg::WDT_MODE_WD_RST) begin
      rst_act_reg <= 1'b1;
      rst_cnt_reg <= (src_reg == wdt_pkg::SRC_4K) ? 21'(RST_FAST_CYC - 1) : 21'(RST_SLOW_CYC - 1);
    end else if (val_wr) begin
      rst_act_reg <= 1'b0;
      rst_cnt_reg <= 21'h000000;
    end else if (rst_act_reg) begin
      if (rst_cnt_reg == 21'h000000) begin
        rst_act_reg <= 1'b0;
      end else begin
        rst_cnt_reg <= rst_cnt_reg - 21'h000001;
      end
    end
  end

  // Pulsed interrupt runs from an enabled countdown or minute/second flag set until the next fast tick.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_reg <= 1'b0;
    end else if ((cd_hit && cfg_reg[0]) || (ms_set && cfg_reg[1])) begin
      pulse_reg <= 1'b1;
    end else if (t4k) begin
      pulse_reg <= 1'b0;
    end
  end

  // Interrupt output. The watchdog source follows its flag, so a status read
  // that clears the flag also releases the line.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= !((wd_expired_reg && mode_reg == wdt_pkg::WDT_MODE_WD_INT) ||
                     (pulse_sel_reg ? pulse_reg :
                      ((cd_done_reg && cd_mode && cfg_reg[0]) || (ms_flag_reg && cfg_reg[1]))));
    end
  end

  // Read data and error are captured in the setup cycle and stand until the next setup.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      slverr_reg <= !mapped(paddr_i);
      if (pwrite_i) begin
        prdata_reg <= 32'h00000000;
      end else if (paddr_i == wdt_pkg::ADDR_STATUS) begin
        prdata_reg <= {24'h000000, ms_flag_reg, wd_expired_reg, 2'h0, cd_done_reg, 3'h0};
      end else if (paddr_i == wdt_pkg::ADDR_IRQ_CFG) begin
        prdata_reg <= {30'h00000000, cfg_reg};
      end else if (paddr_i == wdt_pkg::ADDR_TIMER_CONTROL) begin
        prdata_reg <= {24'h000000, mode_reg, pulse_sel_reg, 3'h0, src_reg};
      end else if (paddr_i == wdt_pkg::ADDR_TIMER_VALUE) begin
        prdata_reg <= {24'h000000, cnt_reg};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // Checks on the timer's own outputs and state.
  property p_wd_int;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wd_expired_reg && mode_reg == wdt_pkg::WDT_MODE_WD_INT) |=> !irq_n_o;
  endproperty
  a_wd_int: assert property (p_wd_int) else $error("watchdog interrupt not asserted");

  property p_wd_rst;
    @(posedge clk_i) disable iff (!rst_n_i)
    ($rose(wd_expired_reg) && $past(mode_reg) == wdt_pkg::WDT_MODE_WD_RST) |-> !wd_rst_n_o && !$past(val_wr);
  endproperty
  a_wd_rst: assert property (p_wd_rst) else $error("watchdog reset not asserted");

  property p_rst_width;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_act_reg) |-> rst_cnt_reg == ((src_reg == wdt_pkg::SRC_4K) ?
                                          21'(RST_FAST_CYC - 1) : 21'(RST_SLOW_CYC - 1));
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse width wrong");

  property p_wd_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (wd_expired_reg && wd_mode && !running_reg && !val_wr) |=> $stable(cnt_reg) && !running_reg;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("expired watchdog reloaded");

  property p_val_load;
    @(posedge clk_i) disable iff (!rst_n_i)
    val_wr |=> cnt_reg == $past(pwdata_i[7:0]) && !wd_expired_reg && wd_rst_n_o &&
               running_reg == ($past(pwdata_i[7:0]) != 8'h00);
  endproperty
  a_val_load: assert property (p_val_load) else $error("value write did not restart or stop");

  property p_cd_reload;
    @(posedge clk_i) disable iff (!rst_n_i)
    cd_hit |=> cd_done_reg && cnt_reg == $past(reload_reg) && running_reg;
  endproperty
  a_cd_reload: assert property (p_cd_reload) else $error("countdown did not reload");

  property p_cd_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cd_done_reg && !(stat_wr && !pwdata_i[wdt_pkg::STAT_CD_BIT])) |=> cd_done_reg;
  endproperty
  a_cd_sticky: assert property (p_cd_sticky) else $error("countdown flag lost");

  property p_val_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    (setup && !pwrite_i && paddr_i == wdt_pkg::ADDR_TIMER_VALUE) |=> prdata_o == {24'h000000, $past(cnt_reg)};
  endproperty
  a_val_read: assert property (p_val_read) else $error("value read not live counter");

  property p_cd_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cd_done_reg && cd_mode && cfg_reg[0] && !pulse_sel_reg) |=> !irq_n_o;
  endproperty
  a_cd_irq: assert property (p_cd_irq) else $error("countdown interrupt missing");

  property p_wd_clear_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    (stat_rd && !wd_hit) |=> !wd_expired_reg;
  endproperty
  a_wd_clear_read: assert property (p_wd_clear_read) else $error("status read left watchdog flag");

  c_wd_int: cover property (@(posedge clk_i) disable iff (!rst_n_i) wd_hit && mode_reg == wdt_pkg::WDT_MODE_WD_INT);
  c_wd_rst: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(rst_act_reg));
  c_cd_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) cd_hit);
  c_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(pulse_reg) && pulse_sel_reg);
endmodule
`default_nettype wire

// [bench/wdt_mcu_model.sv]
// Model of the supervised microcontroller that watches the timer's interrupt and reset lines.
`timescale 1ns/1ns
`default_nettype none
module wdt_mcu_model (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Bench reset, active low.
  input wire logic irq_n_i, // Interrupt line from the timer, active low.
  input wire logic wd_rst_n_i, // Reset line from the timer, active low.
  output int rst_width_o, // Cycles the last reset pulse lasted.
  output int rst_pulses_o, // Reset pulses taken so far.
  output logic irq_in_rst_o // Set once the interrupt was seen low while reset was low.
);
  int low_cnt;
  // The processor sits in reset while the line is low, so it can only time the pulse and note stray interrupts.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 0;
      rst_width_o <= 0;
      rst_pulses_o <= 0;
      irq_in_rst_o <= 1'b0;
    end else if (wd_rst_n_i === 1'b0) begin
      low_cnt <= low_cnt + 1;
      if (irq_n_i === 1'b0) irq_in_rst_o <= 1'b1;
    end else if (low_cnt != 0) begin
      rst_width_o <= low_cnt;
      rst_pulses_o <= rst_pulses_o + 1;
      low_cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// [bench/watchdog_countdown_timer_tb.sv]
// Self-checking testbench of the watchdog and countdown timer.
`timescale 1ns/1ns
`default_nettype none
module watchdog_countdown_timer_tb;
  localparam int TK = 8;
  localparam int RF = 4;
  localparam int RS = 16;
  localparam logic [11:0] A_CTL = wdt_pkg::ADDR_TIMER_CONTROL;
  localparam logic [11:0] A_VAL = wdt_pkg::ADDR_TIMER_VALUE;
  localparam logic [11:0] A_ST = wdt_pkg::ADDR_STATUS;
  localparam logic [11:0] A_CFG = wdt_pkg::ADDR_IRQ_CFG;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} wdt_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ms_event = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq_n, wd_rst_n, er, irq_rst;
  int bad_count = 0, n_checks = 0, cyc, p, rst_width, rst_pulses;
  wdt_row_t rows [8];
  // Short counts keep the run brief; every timing expectation below is scaled from them.
  wdt_timer #(.TICK_4K_CYC(TK), .RST_FAST_CYC(RF), .RST_SLOW_CYC(RS)) i_wdt_timer (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ms_event_i(ms_event),
    .irq_n_o(irq_n), .wd_rst_n_o(wd_rst_n));
  wdt_mcu_model i_wdt_mcu_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_n_i(irq_n), .wd_rst_n_i(wd_rst_n),
    .rst_width_o(rst_width), .rst_pulses_o(rst_pulses), .irq_in_rst_o(irq_rst));
  // Clock of 100 MHz.
  always #5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, r, x);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string msg);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, r, x);
    chk(r, e, msg);
  endtask
  task automatic wait_irq(input logic lvl, input int lim, output int c);
    c = 0;
    while (irq_n !== lvl && c < lim) begin
      @(posedge clk_i);
      c++;
    end
    chk(32'(irq_n), 32'(lvl), "irq level not reached");
  endtask
  task automatic wait_rst(input int lim);
    int c;
    c = 0;
    while ((rst_pulses == p || wd_rst_n !== 1'b1) && c < lim) begin
      @(posedge clk_i);
      c++;
    end
    chk(rst_pulses, p + 1, "reset pulse missing");
  endtask
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk({30'h00000000, irq_n, wd_rst_n}, 32'h00000003, "outputs idle after reset");
    rdc(A_CTL, 32'h03, "control reset value");
    rdc(A_VAL, 32'h00, "value reset value");
    rdc(A_ST, 32'h00, "status reset value");
    rdc(A_CFG, 32'h00, "irq config reset value");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence: register rows first, then the timing cases.
  initial begin
    rows = '{'{A_CTL, 32'h0, 32'h00, 1'b0}, '{A_CTL, 32'hffff_ff21, 32'h21, 1'b0},
             '{A_CTL, 32'h1e, 32'h02, 1'b0}, '{A_CTL, 32'h03, 32'h03, 1'b0}, '{A_CFG, 32'hff, 32'h03, 1'b0},
             '{A_VAL, 32'h5a, 32'h5a, 1'b0}, '{A_VAL, 32'h00, 32'h00, 1'b0}, '{12'h0c0, 32'hff, 32'h0, 1'b1}};
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rd, er);
      chk(32'(er), 32'(rows[i].err), "write error flag");
      apb(1'b0, rows[i].a, 32'h0, rd, er);
      chk(rd, rows[i].e, "readback");
      chk(32'(er), 32'(rows[i].err), "read error flag");
    end
    // Countdown with a level interrupt; clears must fit inside one 3-tick period.
    wr(A_CFG, 32'h01);
    wr(A_VAL, 32'h03);
    wr(A_CTL, 32'h40);
    wait_irq(1'b0, 6 * TK, cyc);
    chk(32'(cyc >= 3 * TK && cyc <= 4 * TK + 2), 32'h1, "first period length");
    rdc(A_ST, 32'h08, "countdown flag");
    chk(32'(irq_n), 32'h0, "level irq");
    wr(A_ST, 32'h88);
    rdc(A_ST, 32'h08, "flag kept by one");
    wr(A_ST, 32'h00);
    rdc(A_ST, 32'h00, "flag cleared by zero");
    chk(32'(irq_n), 32'h1, "level irq follows flag");
    apb(1'b0, A_VAL, 32'h0, rd, er);
    chk(32'(rd >= 1 && rd <= 3), 32'h1, "live counter");
    wr(A_CFG, 32'h00);
    repeat (4 * TK) @(posedge clk_i);
    chk(32'(irq_n), 32'h1, "irq masked");
    rdc(A_ST, 32'h08, "flag set again after reload");
    // Pulsed style: the line pulses while the flag stays set.
    wr(A_CTL, 32'h60);
    wr(A_CFG, 32'h01);
    wr(A_ST, 32'h00);
    wait_irq(1'b0, 4 * TK + 4, cyc);
    wait_irq(1'b1, TK + 2, cyc);
    rdc(A_ST, 32'h08, "flag outlives pulse");
    wr(A_VAL, 32'h00);
    wr(A_ST, 32'h00);
    repeat (6 * TK) @(posedge clk_i);
    rdc(A_ST, 32'h00, "stopped countdown");
    // Watchdog raising the interrupt.
    wr(A_CTL, 32'h80);
    wr(A_VAL, 32'h02);
    wait_irq(1'b0, 3 * TK + 4, cyc);
    rdc(A_VAL, 32'h01, "expired count");
    repeat (5 * TK) @(posedge clk_i);
    rdc(A_VAL, 32'h01, "no reload");
    chk(32'(wd_rst_n), 32'h1, "reset idle in interrupt mode");
    wr(A_ST, 32'hff);
    wr(A_ST, 32'h00);
    chk(32'(irq_n), 32'h0, "flag survives writes");
    rdc(A_ST, 32'h40, "watchdog flag");
    rdc(A_ST, 32'h00, "flag cleared by read");
    chk(32'(irq_n), 32'h1, "irq released by read");
    // A serviced watchdog never fires; a zero write disarms an expired one.
    for (int k = 0; k < 6; k++) begin
      wr(A_VAL, 32'h04);
      repeat (2 * TK) @(posedge clk_i);
    end
    chk(32'(irq_n), 32'h1, "serviced watchdog quiet");
    wait_irq(1'b0, 5 * TK + 4, cyc);
    wr(A_VAL, 32'h00);
    repeat (6 * TK) @(posedge clk_i);
    chk(32'(irq_n), 32'h1, "zero write clears irq");
    rdc(A_ST, 32'h00, "zero write clears flag");
    // Watchdog driving reset on the fast and a slow source.
    p = rst_pulses;
    wr(A_CTL, 32'hc0);
    wr(A_VAL, 32'h01);
    wait_rst(3 * TK + RF + 4);
    chk(rst_width, RF, "fast reset pulse");
    chk(32'(irq_rst), 32'h0, "irq quiet in reset mode");
    rdc(A_ST, 32'h40, "flag behind reset");
    p = rst_pulses;
    wr(A_CTL, 32'hc1);
    wr(A_VAL, 32'h01);
    wait_rst(2 * 64 * TK + RS + 8);
    chk(rst_width, RS, "slow reset pulse");
    rdc(A_ST, 32'h40, "flag behind slow reset");
    // Minute/second event sets its own flag.
    @(posedge clk_i);
    ms_event <= 1'b1;
    @(posedge clk_i);
    ms_event <= 1'b0;
    rdc(A_ST, 32'h80, "minute flag");
    wr(A_ST, 32'h00);
    rdc(A_ST, 32'h00, "minute flag cleared");
    // A new n written mid-period loads at once and is reloaded later; then a reset mid-run.
    wr(A_CTL, 32'h40);
    wr(A_VAL, 32'h02);
    wr(A_VAL, 32'h05);
    rdc(A_VAL, 32'h05, "new n loaded at once");
    wait_irq(1'b0, 6 * TK + 4, cyc);
    rdc(A_VAL, 32'h05, "new n reloaded");
    do_reset();
    results();
  end
  // Cuts a hang short; the whole sequence needs far fewer cycles.
  initial begin
    #200000;
    bad_count++;
    $display("[ERR] %0t watchdog timeout", $time);
    results();
  end
endmodule
`default_nettype wire
